//--- logic/gpc_pkg.sv
package gpc_pkg;

   // Pin count and register location
   localparam int NUM_PINS = 5;
   localparam logic [7:0] CFG_ADDR = 8'h4D;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   // Writable bits: 15 and 1 stay zero
   localparam logic [15:0] CFG_WMASK = 16'h7FFD;

   // Field positions inside the pin configuration word
   localparam int FMT_LSB = 10;
   localparam int DIR_LSB = 5;
   localparam int SRC_LSB = 0;

   // Pins that carry a dedicated function
   localparam int PIN_MHD = 0;
   localparam int PIN_FAULT = 2;
   localparam int PIN_OCC_A = 3;
   localparam int PIN_OCC_B = 4;

   // Layout of one pulse-width configuration word (same for low and high level)
   localparam int PWM_CFG_W = 16;
   localparam int PWM_TB_LSB = 14;
   localparam int PWM_HC_LSB = 7;
   localparam int PWM_LC_LSB = 0;
   localparam int PWM_CNT_W = 7;

   // Time base unit: one tick at time base 0, doubled per time base step
   localparam int CLK_PERIOD_NS = 10;
   localparam int TB_BASE_TIME_NS = 1000;
   localparam logic [15:0] TB_BASE_CYCLES = 16'(TB_BASE_TIME_NS / CLK_PERIOD_NS);
   localparam logic [6:0] PWM_WIDTH_MAX = 7'h7F;

   // Output waveform phase
   typedef enum {PH_HIGH, PH_LOW} gpc_phase_t;

   // Distance between a measured width and a configured width
   function automatic logic [6:0] gpc_abs_diff(input logic [6:0] a, input logic [6:0] b);
      gpc_abs_diff = (a >= b) ? 7'(a - b) : 7'(b - a);
   endfunction : gpc_abs_diff

endpackage : gpc_pkg

//--- logic/gpc_pwm_channel.sv
module gpc_pwm_channel import gpc_pkg::*; (
   // Clock and control
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic enable,
   // Value to code and synchronised pin level
   input wire logic data_in,
   input wire logic pin_level,
   // Pulse-width counts for logic low and logic high
   input wire logic [6:0] ll_hc,
   input wire logic [6:0] ll_lc,
   input wire logic [6:0] lh_hc,
   input wire logic [6:0] lh_lc,
   input wire logic [1:0] time_base,
   // Coded output and decoded input
   output logic pwm_out,
   output logic decoded
);

   logic [15:0] presc_reg, presc_next;
   logic [6:0] cnt_reg, cnt_next;
   logic [6:0] width_reg, width_next;
   gpc_phase_t phase_reg, phase_next;
   logic pwm_reg, pwm_next;
   logic dec_reg, dec_next;
   logic prev_reg, prev_next;
   logic [15:0] tick_limit;
   logic tick;
   logic [6:0] hc;
   logic [6:0] lc;

   // Tick divider and counts picked by the value being coded
   always_comb begin
      tick_limit = 16'(TB_BASE_CYCLES << time_base);
      tick = (presc_reg >= 16'(tick_limit - 16'h0001));
      hc = data_in ? lh_hc : ll_hc;
      lc = data_in ? lh_lc : ll_lc;
   end

   // Next state of generator and decoder
   always_comb begin
      presc_next = presc_reg;
      cnt_next = cnt_reg;
      width_next = width_reg;
      phase_next = phase_reg;
      pwm_next = pwm_reg;
      dec_next = dec_reg;
      prev_next = pin_level;
      if (!enable) begin
         // Idle so a newly enabled pin starts a fresh period
         presc_next = 16'h0000;
         cnt_next = 7'h00;
         width_next = 7'h00;
         phase_next = PH_HIGH;
         pwm_next = 1'b0;
         dec_next = 1'b0;
      end else begin
         presc_next = tick ? 16'h0000 : 16'(presc_reg + 16'h0001);
         // Counts are read live, so a data change takes effect mid period
         if (tick) begin
            case (phase_reg)
               PH_HIGH: begin
                  if (7'(cnt_reg + 7'h01) >= hc) begin
                     phase_next = PH_LOW;
                     cnt_next = 7'h00;
                  end else begin
                     cnt_next = 7'(cnt_reg + 7'h01);
                  end
               end
               PH_LOW: begin
                  if (7'(cnt_reg + 7'h01) >= lc) begin
                     phase_next = PH_HIGH;
                     cnt_next = 7'h00;
                  end else begin
                     cnt_next = 7'(cnt_reg + 7'h01);
                  end
               end
               default: begin
                  phase_next = PH_HIGH;
                  cnt_next = 7'h00;
               end
            endcase
         end
         pwm_next = (phase_next == PH_HIGH);
         // High time measured in ticks, saturating so long pulses stay valid
         if (pin_level && !prev_reg) begin
            width_next = 7'h00;
         end else if (pin_level && tick && (width_reg != PWM_WIDTH_MAX)) begin
            width_next = 7'(width_reg + 7'h01);
         end
         // Nearest configured high time wins, ties decode as low
         if (!pin_level && prev_reg) begin
            dec_next = gpc_abs_diff(width_reg, lh_hc) < gpc_abs_diff(width_reg, ll_hc);
         end
      end
   end

   // Registers; reset acts even while frozen
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         presc_reg <= 16'h0000;
         cnt_reg <= 7'h00;
         width_reg <= 7'h00;
         phase_reg <= PH_HIGH;
         pwm_reg <= 1'b0;
         dec_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else if (ce) begin
         presc_reg <= presc_next;
         cnt_reg <= cnt_next;
         width_reg <= width_next;
         phase_reg <= phase_next;
         pwm_reg <= pwm_next;
         dec_reg <= dec_next;
         prev_reg <= prev_next;
      end
   end

   assign pwm_out = pwm_reg;
   assign decoded = dec_reg;

endmodule : gpc_pwm_channel

//--- logic/gpc_pin_config.sv
// Behaviour
// - Config register at 4Dh, resets 0000h.
// - Bits 14..10 pick static or pulse-coded format.
// - Static input: value is synchronised pin level.
// - Static output: drive level, ignore pulse settings.
// - Coded input: value decoded from pulse width.
// - Coded output: waveform from pulse-width settings.
// - Readback static when 0, pulse-decoded when 1.
// - Bits 9..5 set direction, 1 output.
// - Bit 4: pin 4 comparator B or data.
// - Bit 3: pin 3 comparator A or data.
// - Bit 2: pin 2 fault or data.
// - Bit 0: pin 0 host-detect or data.
// - Source select matters only for output pins.
// - Bits 15, 1 read zero; pin 1 data.
// - Static data output drives output data bit.
module gpc_pin_config import gpc_pkg::*; (
   // Clock, reset, enable
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // Register port from the serial host interface
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   // Output data and pulse-width configuration, pin p in slice p
   input wire logic [4:0] pin_output_values,
   input wire logic [79:0] pin_pwm_low_level_cfg,
   input wire logic [79:0] pin_pwm_high_level_cfg,
   // Dedicated function sources
   input wire logic overcurrent_cmp_a_out,
   input wire logic overcurrent_cmp_b_out,
   input wire logic device_fault,
   input wire logic missing_host_detect,
   // Pins
   input wire logic [4:0] pin_in,
   output logic [4:0] pin_out,
   output logic [4:0] pin_oe,
   // Logic value seen on each pin
   output logic [4:0] pin_value
);

   // Register port state
   logic [15:0] cfg_reg, cfg_next;
   logic [15:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   // Synchroniser and pin state
   logic [4:0] sync1_reg, sync1_next;
   logic [4:0] sync2_reg, sync2_next;
   logic [4:0] out_reg, out_next;
   logic [4:0] value_reg, value_next;
   // Decoded fields and per-pin signals
   logic [4:0] fmt;
   logic [4:0] dir;
   logic [4:0] src;
   logic [4:0] dedicated;
   logic [4:0] level;
   logic [4:0] pwm_wave;
   logic [4:0] pwm_dec;

   // Address decode, shared by the write and read paths
   function automatic logic cfg_hit(input logic [7:0] addr);
      cfg_hit = (addr == CFG_ADDR);
   endfunction : cfg_hit

   // One count field of pin p's pulse-width word in a packed bus
   function automatic logic [6:0] pwm_count(input logic [79:0] cfg_bus, input int p,
      input int lsb);
      pwm_count = cfg_bus[p*PWM_CFG_W + lsb +: PWM_CNT_W];
   endfunction : pwm_count

   // Field split; pin 1 has no dedicated source so its select is forced to data
   always_comb begin
      fmt = cfg_reg[FMT_LSB +: NUM_PINS];
      dir = cfg_reg[DIR_LSB +: NUM_PINS];
      src = cfg_reg[SRC_LSB +: NUM_PINS];
      src[1] = 1'b1;
      dedicated = pin_output_values;
      dedicated[PIN_OCC_B] = overcurrent_cmp_b_out;
      dedicated[PIN_OCC_A] = overcurrent_cmp_a_out;
      dedicated[PIN_FAULT] = device_fault;
      dedicated[PIN_MHD] = missing_host_detect;
   end

   // Register access: writes masked, unmapped reads answer zero
   always_comb begin
      cfg_next = cfg_reg;
      rdata_next = rdata_reg;
      rvalid_next = reg_rd;
      if (reg_wr && cfg_hit(reg_addr)) begin
         cfg_next = reg_wdata & CFG_WMASK;
      end
      if (reg_rd) begin
         rdata_next = cfg_hit(reg_addr) ? cfg_reg : 16'h0000;
      end
   end

   // Two-stage synchroniser; only the second stage is used downstream
   always_comb begin
      sync1_next = pin_in;
      sync2_next = sync1_reg;
   end

   // Pin drive and readback, registered so every output leaves a flop
   always_comb begin
      out_next = 5'h00;
      value_next = 5'h00;
      for (int p = 0; p < NUM_PINS; p++) begin
         // Source only steers an output; an input pin never looks at it
         level[p] = dir[p] ? (src[p] ? pin_output_values[p] : dedicated[p]) : 1'b0;
         if (dir[p]) begin
            // Static drive ignores the pulse settings entirely
            out_next[p] = fmt[p] ? pwm_wave[p] : level[p];
         end
         // Same path reads back inputs and driven outputs
         value_next[p] = fmt[p] ? pwm_dec[p] : sync2_reg[p];
      end
   end

   // One coder and decoder per pin; time base comes from the low-level word
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      gpc_pwm_channel u_chan (
         .clock(clock),
         .rst_n(rst_n),
         .ce(ce),
         .enable(fmt[g]),
         .data_in(level[g]),
         .pin_level(sync2_reg[g]),
         .ll_hc(pwm_count(pin_pwm_low_level_cfg, g, PWM_HC_LSB)),
         .ll_lc(pwm_count(pin_pwm_low_level_cfg, g, PWM_LC_LSB)),
         .lh_hc(pwm_count(pin_pwm_high_level_cfg, g, PWM_HC_LSB)),
         .lh_lc(pwm_count(pin_pwm_high_level_cfg, g, PWM_LC_LSB)),
         .time_base(pin_pwm_low_level_cfg[g*PWM_CFG_W + PWM_TB_LSB +: 2]),
         .pwm_out(pwm_wave[g]),
         .decoded(pwm_dec[g])
      );
   end

   // Register port flops; reset wins over the clock enable
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg_reg <= CFG_RESET;
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
      end else if (ce) begin
         cfg_reg <= cfg_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // Synchroniser flops, cleared so no false level follows reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1_reg <= 5'h00;
         sync2_reg <= 5'h00;
      end else if (ce) begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
      end
   end

   // Pin drive and readback flops
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out_reg <= 5'h00;
         value_reg <= 5'h00;
      end else if (ce) begin
         out_reg <= out_next;
         value_reg <= value_next;
      end
   end

   // Direction bits drive the enables straight from the register
   assign pin_oe = dir;
   assign pin_out = out_reg;
   assign pin_value = value_reg;
   assign reg_rdata = rdata_reg;
   assign reg_rvalid = rvalid_reg;

endmodule : gpc_pin_config

//--- sim/gpc_pin_config_assertions.sv
module gpc_pin_config_assertions import gpc_pkg::*; (
   // Clock and register port
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid,
   // Sources and pins
   input wire logic [4:0] pin_output_values,
   input wire logic overcurrent_cmp_a_out,
   input wire logic overcurrent_cmp_b_out,
   input wire logic device_fault,
   input wire logic missing_host_detect,
   input wire logic [4:0] pin_in,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   input wire logic [4:0] pin_value
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   logic [15:0] cfg_reg, cfg_next;
   // Answer owed to the last accepted read; frozen with the clock enable
   logic [15:0] rd_exp_reg;
   logic [4:0] exp_reg, gp_reg, ded_reg, in_reg, p1_reg, p2_reg, p3_reg, f1_reg, f2_reg, f3_reg;
   logic [4:0] sel;
   // Pin 1 has no dedicated source, so it always takes data
   assign sel = cfg_reg[4:0] | 5'h02;
   // Shadow of the word; a frozen clock enable drops the write
   always_comb begin
      cfg_next = cfg_reg;
      if (ce && reg_wr && reg_addr == CFG_ADDR)
         cfg_next = reg_wdata & CFG_WMASK;
   end
   // Format history starts as all ones so the synchroniser may settle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg_reg <= CFG_RESET;
         rd_exp_reg <= 16'h0000;
         {exp_reg, gp_reg, ded_reg, in_reg, p1_reg, p2_reg, p3_reg} <= '0;
         {f1_reg, f2_reg, f3_reg} <= '1;
      end else if (ce) begin
         cfg_reg <= cfg_next;
         if (reg_rd)
            rd_exp_reg <= (reg_addr == CFG_ADDR) ? cfg_reg : 16'h0000;
         exp_reg <= cfg_reg[9:5] & ((sel & pin_output_values) | (~sel & {overcurrent_cmp_b_out,
            overcurrent_cmp_a_out, device_fault, 1'b0, missing_host_detect}));
         gp_reg <= cfg_reg[9:5] & ~cfg_reg[14:10] & sel;
         ded_reg <= cfg_reg[9:5] & ~cfg_reg[14:10] & ~sel;
         in_reg <= ~cfg_reg[9:5];
         {p3_reg, p2_reg, p1_reg} <= {p2_reg, p1_reg, pin_in};
         {f3_reg, f2_reg, f1_reg} <= {f2_reg, f1_reg, cfg_reg[14:10]};
      end
   end
   AST_READBACK: assert property (reg_rvalid |-> reg_rdata == rd_exp_reg)
      else $error("readback");
   AST_RD_ANSWER: assert property (ce && reg_rd |=> reg_rvalid)
      else $error("no answer");
   AST_RV_CAUSE: assert property (reg_rvalid |->
      $past(reg_rd && ce) || $past(reg_rvalid && !ce)) else $error("stray answer");
   AST_RDATA_HOLD: assert property (!reg_rvalid |-> $stable(reg_rdata))
      else $error("rdata moved");
   AST_OE_DIR: assert property (pin_oe == cfg_reg[9:5]) else $error("enable");
   AST_GP_DRIVE: assert property (((pin_out ^ exp_reg) & gp_reg) == 5'h00)
      else $error("data drive");
   AST_DED_DRIVE: assert property (((pin_out ^ exp_reg) & ded_reg) == 5'h00)
      else $error("source drive");
   AST_IN_QUIET: assert property ((pin_out & in_reg) == 5'h00)
      else $error("input driven");
   AST_STATIC_IN: assert property (((pin_value ^ p3_reg) &
      ~(cfg_reg[14:10] | f1_reg | f2_reg | f3_reg)) == 5'h00) else $error("static value");
endmodule : gpc_pin_config_assertions

bind gpc_pin_config gpc_pin_config_assertions chk (.*);

//--- sim/gpc_pin_partner.sv
module gpc_pin_partner (
   // Device side of each pin
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   // Level the outside logic puts on pins it owns
   input wire logic [4:0] ext_level,
   output logic [4:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // The device wins on pins it drives, so outputs read back
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gpc_pin_partner

//--- sim/gpc_pin_config_tb.sv
module gpc_pin_config_tb import gpc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Stimulus is written at the falling edge
   logic clock, rst_n = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
   logic overcurrent_cmp_a_out = 1'b0, overcurrent_cmp_b_out = 1'b0;
   logic device_fault = 1'b0, missing_host_detect = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
   logic [4:0] pin_output_values = 5'h00, ext_level = 5'h00, pin_in, pin_out, pin_oe, pin_value;
   // Logic 0 is 4 ticks high, logic 1 is 1 tick high and 2 low
   logic [79:0] pin_pwm_low_level_cfg = {5{16'h0201}};
   logic [79:0] pin_pwm_high_level_cfg = {5{16'h0082}};
   logic [15:0] exp_q[$];
   int n_errors = 0, total_checks = 0, cycles = 0;
   logic ce_seen = 1'b1;

   gpc_pin_config uut (.*);
   gpc_pin_partner model (.*);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, want, seen);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   // One register cycle; a read notes what it should return
   task automatic bus(input logic w, r, input logic [7:0] a, input logic [15:0] d, e);
      if (r)
         exp_q.push_back(e);
      reg_wr = w;
      reg_rd = r;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
   endtask : bus

   task automatic step(input int n);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (n) @(negedge clock);
   endtask : step

   // Time one high and one low phase of the coded waveform on pin 1
   task automatic measure(input logic [15:0] eh, el);
      int h = 0;
      int l = 0;
      // Skip the period in progress, which a start or data change may cut short
      while (pin_out[1] !== 1'b1) @(negedge clock);
      while (pin_out[1] !== 1'b0) @(negedge clock);
      while (pin_out[1] !== 1'b1) @(negedge clock);
      for (; pin_out[1] === 1'b1; h++) @(negedge clock);
      for (; pin_out[1] === 1'b0; l++) @(negedge clock);
      check("high time", 16'(h), eh);
      check("low time", 16'(l), el);
      check("readback", 16'(pin_value[1]), 16'(pin_output_values[1]));
   endtask : measure

   task automatic pulse(input int n, input logic e);
      ext_level[4] = 1'b1;
      step(n);
      ext_level[4] = 1'b0;
      step(10);
      check("coded input", 16'(pin_value[4]), 16'(e));
   endtask : pulse

   // Clock enable as the last rising edge saw it; a frozen edge holds the old answer
   always @(posedge clock)
      ce_seen <= ce;

   // Read answers are matched against the oldest note
   always @(negedge clock)
      if (reg_rvalid === 1'b1 && ce_seen === 1'b1)
         check("read data", reg_rdata, exp_q.pop_front());

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         n_errors++;
         conclude();
      end
   end

   initial begin
      void'($urandom(73512));
      repeat (5) @(negedge clock);
      rst_n = 1'b1;
      // Reset value, read during a write, a foreign address, frozen enable
      bus(0, 1, CFG_ADDR, 16'h0000, CFG_RESET);
      bus(1, 1, CFG_ADDR, 16'hFFFF, CFG_RESET);
      bus(1, 1, 8'h4C, 16'h0000, 16'h0000);
      ce = 1'b0;
      bus(1, 0, CFG_ADDR, 16'h0000, 16'h0000);
      ce = 1'b1;
      bus(0, 1, CFG_ADDR, 16'h0000, 16'h7FFD);
      for (int i = 0; i < 24; i++) begin
         v = 16'($urandom);
         if (i[0])
            v[14:10] = 5'h00;
         {pin_output_values, ext_level, overcurrent_cmp_a_out, overcurrent_cmp_b_out,
            device_fault, missing_host_detect} = 14'($urandom);
         bus(1, 0, CFG_ADDR, v, 16'h0000);
         bus(0, 1, CFG_ADDR, 16'h0000, v & CFG_WMASK);
         step(4);
      end
      // Static data outputs ignore the pulse settings
      bus(1, 0, CFG_ADDR, 16'h03FD, 16'h0000);
      step(2);
      check("pin enable", 16'(pin_oe), 16'h001F);
      check("data drive", 16'(pin_out), 16'(pin_output_values));
      // Dedicated sources, with those pins made outputs first
      bus(1, 0, CFG_ADDR, 16'h03E0, 16'h0000);
      step(2);
      check("source drive", 16'(pin_out), 16'({overcurrent_cmp_b_out, overcurrent_cmp_a_out,
         device_fault, pin_output_values[1], missing_host_detect}));
      bus(1, 0, CFG_ADDR, 16'h001D, 16'h0000);
      step(4);
      check("input drive", 16'({pin_out, pin_oe}), 16'h0000);
      check("input value", 16'(pin_value), 16'(ext_level));
      // Coded output on pin 1 for both values, read back through the wire
      pin_output_values[1] = 1'b1;
      bus(1, 0, CFG_ADDR, 16'h0840, 16'h0000);
      measure(16'h0064, 16'h00C8);
      pin_output_values[1] = 1'b0;
      measure(16'h0190, 16'h0064);
      // Time base one doubles every tick
      pin_pwm_low_level_cfg[31:30] = 2'b01;
      pin_output_values[1] = 1'b1;
      measure(16'h00C8, 16'h0190);
      // Coded input on pin 4
      bus(1, 0, CFG_ADDR, 16'h4000, 16'h0000);
      ext_level[4] = 1'b0;
      step(20);
      pulse(100, 1'b1);
      pulse(400, 1'b0);
      // A second reset in mid-run
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      bus(0, 1, CFG_ADDR, 16'h0000, CFG_RESET);
      step(2);
      check("open reads", 16'(exp_q.size()), 16'h0000);
      conclude();
   end
endmodule : gpc_pin_config_tb
